// ### verilog/blk_pkg.sv
package blk_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_LOCK = 8'h08;

    // Control register bit positions.
    localparam int CTRL_SERR_EN = 0;
    localparam int CTRL_MABT_MODE = 1;
    localparam int CTRL_MTO_SERR_EN = 2;

    // Status register bit positions, write one to clear.
    localparam int STAT_SIG_SERR = 0;
    localparam int STAT_TABT_SIG = 1;
    localparam int STAT_TABT_RCV = 2;
    localparam int STAT_MABT_RCV = 3;

    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [3:0] STAT_RESET = 4'h0;

    // Request drop after retry, disconnect or abort, in clocks.
    localparam logic [1:0] REQ_HOLDOFF = 2'h2;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Parking values for the primary address, command and parity lines.
    localparam logic [31:0] PARK_AD = 32'h0000_0000;
    localparam logic [3:0] PARK_CBE = 4'h0;

    // Lock-sequence state.
    typedef enum logic [1:0] {
        BLK_UNLOCKED = 2'b00,
        BLK_PENDING = 2'b01,
        BLK_HELD = 2'b10
    } blk_lock_t;

    // Captured locked request.
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] cmd;
        logic [3:0] be;
        logic par;
    } blk_req_t;

    // Synchroniser stages for one pin input bundle.
    typedef struct packed {
        logic [2:0] frame;
        logic [2:0] lock;
        logic [2:0] gnt;
    } blk_sync_t;

endpackage : blk_pkg

// ### verilog/blk_lock_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module blk_lock_ctl
    import blk_pkg::*;
(
    input wire logic clk_sys, // 125 MHz system clock.
    input wire logic nrst, // Synchronous active-low reset.
    // AXI4-Lite slave.
    input wire logic [7:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [7:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    // Primary pins.
    input wire logic primFrameN, // Primary frame, active low.
    input wire logic primLockN, // Primary lock, active low.
    input wire logic primGntN, // Primary grant, active low.
    output logic primReqN, // Primary request, active low.
    output logic primStart, // Begin primary transaction; high while request and registered grant are both on.
    output logic [31:0] primAdOut, // Parked address/data value.
    output logic [3:0] primCbeOut, // Parked command/byte enables.
    output logic primParOut, // Parked parity.
    output logic primParkOe, // Drive parked lines.
    output logic sysErrN, // System error, active low.
    // Primary target decode from the transaction engine.
    input wire logic lockedReqHit, // Locked request for downstream target seen.
    input wire logic [31:0] reqAddr, // Address of current primary request.
    input wire logic [3:0] reqCmd, // Command of current primary request.
    input wire logic [3:0] reqBe, // Byte enables of current primary request.
    input wire logic reqPar, // Parity of current primary request.
    input wire logic reqIsRead, // Current request is a read.
    input wire logic reqIsPosted, // Current request is a posted memory write.
    input wire logic crossReq, // Any other cross-bridge request seen.
    input wire logic repeatHit, // Locked repeat of a delayed request seen.
    output logic termRetry, // Answer current primary request with retry.
    output logic termTabort, // Answer current primary request with target abort.
    output logic repeatDeliver, // Deliver read data for the locked repeat.
    output logic queueAccept, // Entry may be queued downstream.
    output logic prefetchOk, // Prefetch permitted for memory reads.
    output logic postOk, // Posting permitted for memory writes.
    output blk_req_t lockedReq, // Captured locked request.
    // Secondary side.
    input wire logic secLockN, // Secondary lock, active low.
    input wire logic secIdle, // Secondary bus idle.
    input wire logic lockedAtHead, // Locked read at queue head, older work done.
    input wire logic secDataDone, // Data transfer of the locked read completed.
    input wire logic secRetry, // Target retry on a locked secondary transaction.
    input wire logic secTabort, // Target abort on a locked secondary transaction.
    input wire logic secMabort, // Master abort on a locked secondary transaction.
    input wire logic secPostedEnd, // Locked posted write finished on secondary.
    input wire logic masterTimeout, // Delayed request discard timer expired.
    output logic secReq, // Request secondary bus for the locked read.
    output logic secLockOutN, // Downstream lock drive, active low.
    output logic secLockForward, // Forward locked transactions locked.
    output logic discardLocked, // Pulse: drop locked read and data.
    output logic upLocked, // Upstream forwards as locked, always low.
    // Upstream queue state.
    input wire logic upPostedPend, // Upstream posted write pending.
    input wire logic upPostedSel, // Downstream target select for posted write.
    input wire logic upDelayedHead, // Delayed request fully queued at head.
    input wire logic primTermRetry // Retry, disconnect or abort on primary master.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        blk_sync_t sync;
        logic frameF;
        logic lockF;
        logic gntF;
        blk_lock_t lockSt;
        logic firstDone;
        logic abortPend;
        logic lastPosted;
        logic secHeld;
        blk_req_t req;
        logic [2:0] ctrl;
        logic [3:0] stat;
        logic postSeen;
        logic [1:0] holdCnt;
        logic reqOn;
        logic gntPrev;
        logic parkPar;
        logic serrOut;
        logic awHave;
        logic wHave;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } blk_state_t;

    blk_state_t s_q;
    blk_state_t s_d;

    logic frameN;
    logic lockN;
    logic gntN;
    logic relSeen;
    logic serrEvt;
    logic wrFire;
    logic [3:0] statClr;

    // Change on a pin input counts once the second and third stages agree.
    function automatic logic agreed(input logic [2:0] st, input logic prev);
        agreed = (st[1] == st[2]) ? st[2] : prev;
    endfunction : agreed

    function automatic logic parity36(input logic [31:0] ad, input logic [3:0] cbe);
        parity36 = ^{ad, cbe};
    endfunction : parity36

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Filtered pin levels live in the state, so nothing but stage two reads stage one.
    assign frameN = s_q.frameF;
    assign lockN = s_q.lockF;
    assign gntN = s_q.gntF;

    always_comb
    begin
        s_d = s_q;
        serrEvt = 1'b0;
        relSeen = 1'b0;
        wrFire = 1'b0;
        statClr = 4'h0;
        s_d.sync.frame = {s_q.sync.frame[1:0], primFrameN};
        s_d.sync.lock = {s_q.sync.lock[1:0], primLockN};
        s_d.sync.gnt = {s_q.sync.gnt[1:0], primGntN};
        s_d.frameF = agreed(s_q.sync.frame, s_q.frameF);
        s_d.lockF = agreed(s_q.sync.lock, s_q.lockF);
        s_d.gntF = agreed(s_q.sync.gnt, s_q.gntF);

        // Lock sequence.
        unique case (s_q.lockSt)
            BLK_UNLOCKED:
            begin
                if (lockedReqHit && reqIsRead)
                begin
                    s_d.lockSt = BLK_PENDING;
                    s_d.req = '{addr: reqAddr, cmd: reqCmd, be: reqBe, par: reqPar};
                    s_d.firstDone = 1'b0;
                    s_d.secHeld = 1'b0;
                end
            end
            BLK_PENDING:
            begin
                if (secDataDone)
                    s_d.secHeld = 1'b1;
                if (secTabort || secMabort)
                begin
                    s_d.abortPend = 1'b1;
                    s_d.secHeld = 1'b0;
                end
                else if (secRetry && !s_q.firstDone)
                    s_d.secHeld = 1'b0;
                if (masterTimeout)
                begin
                    s_d.lockSt = BLK_UNLOCKED;
                    s_d.secHeld = 1'b0;
                    serrEvt = s_q.ctrl[CTRL_MTO_SERR_EN];
                end
                else if (repeatHit && s_q.abortPend)
                begin
                    s_d.lockSt = BLK_UNLOCKED;
                    s_d.abortPend = 1'b0;
                end
                else if (repeatHit && s_q.secHeld)
                begin
                    s_d.lockSt = BLK_HELD;
                    s_d.firstDone = 1'b1;
                end
            end
            BLK_HELD:
            begin
                if (secTabort || secMabort)
                    s_d.abortPend = !reqIsPosted;
                if (repeatHit)
                begin
                    s_d.abortPend = 1'b0;
                    s_d.lastPosted = 1'b0;
                end
                if (reqIsPosted && lockedReqHit)
                    s_d.lastPosted = 1'b1;
                if (secPostedEnd && s_q.lastPosted && lockN)
                    relSeen = 1'b1;
                if (!s_q.lastPosted && lockN && frameN)
                    relSeen = 1'b1;
                if (relSeen)
                begin
                    s_d.lockSt = BLK_UNLOCKED;
                    s_d.secHeld = 1'b0;
                    s_d.lastPosted = 1'b0;
                end
            end
            default: s_d.lockSt = BLK_UNLOCKED;
        endcase

        // Locked posted write aborts cannot be reported back upstream.
        if (s_q.lockSt == BLK_HELD && s_q.lastPosted && (secTabort || (secMabort && s_q.ctrl[CTRL_MABT_MODE])))
            serrEvt = 1'b1;

        // Register bus: write address and data taken in either order.
        if (awvalid && !s_q.awHave)
        begin
            s_d.awHave = 1'b1;
            s_d.awAddr = awaddr;
        end
        if (wvalid && !s_q.wHave)
        begin
            s_d.wHave = 1'b1;
            s_d.wData = wdata;
            s_d.wStrb = wstrb;
        end
        if (s_q.awHave && s_q.wHave && !s_q.bValid)
        begin
            wrFire = 1'b1;
            s_d.awHave = 1'b0;
            s_d.wHave = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = RESP_OKAY;
            unique case (s_q.awAddr)
                ADDR_CTRL: if (s_q.wStrb[0]) s_d.ctrl = s_q.wData[2:0];
                ADDR_STAT: if (s_q.wStrb[0]) statClr = s_q.wData[3:0];
                ADDR_LOCK: ;
                default: s_d.bResp = RESP_SLVERR;
            endcase
        end
        if (s_q.bValid && bready)
            s_d.bValid = 1'b0;
        if (arvalid && !s_q.rValid)
        begin
            s_d.rValid = 1'b1;
            s_d.rResp = RESP_OKAY;
            unique case (araddr)
                ADDR_CTRL: s_d.rData = {29'h0, s_q.ctrl};
                ADDR_STAT: s_d.rData = {28'h0, s_q.stat};
                ADDR_LOCK: s_d.rData = {28'h0, s_q.secHeld, s_q.abortPend, s_q.lockSt};
                default:
                begin
                    s_d.rData = 32'h0;
                    s_d.rResp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rValid && rready)
            s_d.rValid = 1'b0;

        // System error gated by its enable; set wins over a status clear.
        s_d.serrOut = serrEvt && s_q.ctrl[CTRL_SERR_EN];
        s_d.stat = s_q.stat & ~statClr;
        if (serrEvt && s_q.ctrl[CTRL_SERR_EN])
            s_d.stat[STAT_SIG_SERR] = 1'b1;
        if (repeatHit && s_q.abortPend)
            s_d.stat[STAT_TABT_SIG] = 1'b1;
        if (s_q.lockSt != BLK_UNLOCKED && secTabort)
            s_d.stat[STAT_TABT_RCV] = 1'b1;
        if (s_q.lockSt != BLK_UNLOCKED && secMabort)
            s_d.stat[STAT_MABT_RCV] = 1'b1;

        // Primary request; a seen select sticks while the write pends, so the request returns after a holdoff.
        s_d.postSeen = upPostedPend && (upPostedSel || s_q.postSeen);
        if (primTermRetry)
            s_d.holdCnt = REQ_HOLDOFF;
        else if (s_q.holdCnt != 2'h0)
            s_d.holdCnt = s_q.holdCnt - 2'h1;
        s_d.reqOn = (s_d.postSeen || upDelayedHead)
            && !primTermRetry && (s_q.holdCnt <= 2'h1);
        s_d.gntPrev = !gntN;
        s_d.parkPar = parity36(PARK_AD, PARK_CBE);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            s_q <= '0;
            s_q.sync <= '1;
            {s_q.frameF, s_q.lockF, s_q.gntF} <= 3'h7;
            s_q.lockSt <= BLK_UNLOCKED;
            s_q.ctrl <= CTRL_RESET;
            s_q.stat <= STAT_RESET;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Responses and the lock drive come straight from state flops.
    assign awready = !s_q.awHave;
    assign wready = !s_q.wHave;
    assign bvalid = s_q.bValid;
    assign bresp = s_q.bResp;
    assign arready = !s_q.rValid;
    assign rvalid = s_q.rValid;
    assign rdata = s_q.rData;
    assign rresp = s_q.rResp;

    assign lockedReq = s_q.req;
    assign termRetry = (lockedReqHit && s_q.lockSt == BLK_UNLOCKED)
        || (crossReq && s_q.lockSt == BLK_PENDING)
        || (repeatHit && s_q.lockSt == BLK_PENDING && !s_q.secHeld && !s_q.abortPend);
    assign termTabort = repeatHit && s_q.abortPend;
    assign repeatDeliver = repeatHit && s_q.lockSt == BLK_PENDING && s_q.secHeld && !s_q.abortPend;
    assign queueAccept = s_q.lockSt != BLK_PENDING;
    assign prefetchOk = s_q.lockSt == BLK_UNLOCKED;
    assign postOk = 1'b1;
    assign secReq = s_q.lockSt == BLK_PENDING && lockedAtHead && !s_q.secHeld
        && (secLockN && secIdle);
    assign secLockOutN = !s_q.secHeld;
    assign secLockForward = s_q.lockSt == BLK_HELD;
    assign discardLocked = masterTimeout && s_q.lockSt == BLK_PENDING;
    assign upLocked = 1'b0;

    assign primReqN = !s_q.reqOn;
    assign primStart = s_q.reqOn && s_q.gntPrev;
    assign primParkOe = s_q.gntPrev && !s_q.reqOn && frameN;
    assign primAdOut = PARK_AD;
    assign primCbeOut = PARK_CBE;
    assign primParOut = s_q.parkPar;
    assign sysErrN = !s_q.serrOut;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_serr_gated: assert property (@(posedge clk_sys) disable iff (!nrst)
        !sysErrN |-> $past(s_q.ctrl[CTRL_SERR_EN]) && s_q.stat[STAT_SIG_SERR])
        else $error("System error raised without enable or status.");
    a_req_holdoff: assert property (@(posedge clk_sys) disable iff (!nrst)
        primTermRetry |=> primReqN [*2])
        else $error("Request not dropped for two clocks after retry.");
    a_lock_release: assert property (@(posedge clk_sys) disable iff (!nrst)
        (s_q.lockSt == BLK_HELD && !s_q.lastPosted && lockN && frameN) |=> secLockOutN)
        else $error("Downstream lock not released after upstream release.");
    a_timeout_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
        (masterTimeout && s_q.lockSt == BLK_PENDING) |=> secLockOutN && s_q.lockSt == BLK_UNLOCKED)
        else $error("Master timeout did not drop the lock.");
    a_queue_block: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_q.lockSt == BLK_PENDING |-> !queueAccept && (!crossReq || termRetry))
        else $error("Cross request accepted while locked read pending.");
    a_first_retry: assert property (@(posedge clk_sys) disable iff (!nrst)
        (lockedReqHit && reqIsRead && s_q.lockSt == BLK_UNLOCKED)
        |-> termRetry ##1 (s_q.lockSt == BLK_PENDING && s_q.req.addr == $past(reqAddr)))
        else $error("Initial locked read not captured and retried.");
    a_abort_unlock: assert property (@(posedge clk_sys) disable iff (!nrst)
        (termTabort && s_q.lockSt == BLK_PENDING) |=> s_q.lockSt == BLK_UNLOCKED && secLockOutN)
        else $error("Abort on initial locked read left a lock.");
    a_start_next: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!gntN && s_d.reqOn && s_q.reqOn) |=> primStart)
        else $error("Granted request did not start next clock.");
    a_no_upstream_lock: assert property (@(posedge clk_sys) disable iff (!nrst)
        !upLocked && (!secLockForward || !secLockOutN))
        else $error("Upstream forwarded locked or lock forward without hold.");

endmodule : blk_lock_ctl

`default_nettype wire

// ### verif/blk_pci_partner.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the primary initiator that locks and for the primary arbiter.
module blk_pci_partner (
    input wire logic clk_sys, // Bus clock.
    input wire logic lockOn, // Bench asks for an exclusive sequence.
    input wire logic primReqN, // Bridge request, active low.
    output logic primFrameN, // Frame, active low.
    output logic primLockN, // Lock, active low.
    output logic primGntN // Grant, active low.
);
    // A lock starts only on an idle bus; frame first, lock one clock later, held until dropped.
    always @(posedge clk_sys)
    begin
        primGntN <= primReqN;
        primFrameN <= !(lockOn && primFrameN && primLockN);
        primLockN <= !(lockOn && (!primFrameN || !primLockN));
    end
endmodule : blk_pci_partner

`default_nettype wire

// ### verif/test_blk_lock_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module test_blk_lock_ctl;
    import blk_pkg::*;
    logic clk_sys, nrst, secLockN, lockOn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, reqAddr, rdata, primAdOut;
    logic [3:0] wstrb, reqCmd, reqBe, primCbeOut;
    logic [1:0] bresp, rresp;
    logic lockedReqHit, reqPar, reqIsRead, reqIsPosted, crossReq, repeatHit, secIdle, lockedAtHead, secDataDone;
    logic secRetry, secTabort, secMabort, secPostedEnd, masterTimeout, upPostedPend, upPostedSel, upDelayedHead;
    logic primTermRetry, arready, rvalid, primReqN, primStart, primParOut, primParkOe, sysErrN, termRetry;
    logic termTabort, repeatDeliver, queueAccept, prefetchOk, postOk, secReq, secLockOutN, secLockForward;
    logic discardLocked, upLocked, primFrameN, primLockN, primGntN;
    blk_req_t lockedReq;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;

    blk_lock_ctl blk_lock_ctl_inst (.clk_sys, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .primFrameN,
        .primLockN, .primGntN, .primReqN, .primStart, .primAdOut, .primCbeOut, .primParOut, .primParkOe, .sysErrN,
        .lockedReqHit, .reqAddr, .reqCmd, .reqBe, .reqPar, .reqIsRead, .reqIsPosted, .crossReq, .repeatHit,
        .termRetry, .termTabort, .repeatDeliver, .queueAccept, .prefetchOk, .postOk, .lockedReq, .secLockN,
        .secIdle, .lockedAtHead, .secDataDone, .secRetry, .secTabort, .secMabort, .secPostedEnd, .masterTimeout,
        .secReq, .secLockOutN, .secLockForward, .discardLocked, .upLocked, .upPostedPend, .upPostedSel,
        .upDelayedHead, .primTermRetry);
    blk_pci_partner blk_pci_partner_inst (.clk_sys, .lockOn, .primReqN, .primFrameN, .primLockN, .primGntN);

    // Free-running 125 MHz clock.
    always #4 clk_sys = ~clk_sys;

    // Hang guard; the whole sequence needs under a hundred cycles.
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Address and data offered together; each released once taken, response held until seen.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
        chk("bresp", bresp, er);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk_sys);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
        chk("rdata", rdata, exp);
        chk("rresp", rresp, er);
    endtask : axi_rd

    // Initial locked read for a downstream target; it must be retried at once.
    task automatic lock_open;
        @(posedge clk_sys);
        {lockedReqHit, reqIsRead, secIdle, lockedAtHead} <= 4'hF;
        #1;
        chk("termRetry", termRetry, 1'b1);
        @(posedge clk_sys);
        {lockedReqHit, reqIsRead} <= 2'h0;
    endtask : lock_open

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    // Main sequence.
    initial
    begin
        {clk_sys, nrst, lockOn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {lockedReqHit, reqPar, reqIsRead, reqIsPosted, crossReq, repeatHit, secIdle, lockedAtHead} = '0;
        {secDataDone, secRetry, secTabort, secMabort, secPostedEnd, masterTimeout, reqAddr, reqCmd, reqBe} = '0;
        {upPostedPend, upPostedSel, upDelayedHead, primTermRetry} = '0;
        {secLockN, wstrb} = 5'h1F;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        axi_rd(ADDR_LOCK, 32'h0, RESP_OKAY);
        axi_rd(8'h0C, 32'h0, RESP_SLVERR);
        axi_wr(ADDR_CTRL, 32'h7, RESP_OKAY);
        axi_rd(ADDR_CTRL, 32'h7, RESP_OKAY);
        $display("test registers done");
        lockOn <= 1'b1;
        reqAddr <= 32'h1234_5678;
        {reqCmd, reqBe, reqPar} <= 9'h0D5;
        repeat (8) @(posedge clk_sys);
        lock_open();
        crossReq <= 1'b1;
        #1;
        chk("captAddr", lockedReq.addr, 32'h1234_5678);
        chk("captRest", {lockedReq.cmd, lockedReq.be, lockedReq.par}, 9'h0D5);
        chk("termRetry", termRetry, 1'b1);
        chk("queueAccept", queueAccept, 1'b0);
        chk("prefetchOk", {prefetchOk, postOk}, 2'h1);
        chk("upLocked", upLocked, 1'b0);
        chk("secReq", secReq, 1'b1);
        @(posedge clk_sys);
        {crossReq, secLockN} <= 2'h0;
        #1;
        chk("secReq", secReq, 1'b0);
        @(posedge clk_sys);
        {secLockN, secDataDone} <= 2'h3;
        @(posedge clk_sys);
        {secDataDone, repeatHit} <= 2'h1;
        #1;
        chk("secLockOutN", secLockOutN, 1'b0);
        chk("repeatDeliver", repeatDeliver, 1'b1);
        @(posedge clk_sys);
        {repeatHit, secRetry} <= 2'h1;
        @(posedge clk_sys);
        secRetry <= 1'b0;
        #1;
        chk("secLockForward", secLockForward, 1'b1);
        chk("secLockOutN", secLockOutN, 1'b0);
        axi_rd(ADDR_LOCK, 32'h0000_000A, RESP_OKAY);
        lockOn <= 1'b0;
        for (int i = 0; i < 12 && secLockOutN !== 1'b1; i++) @(negedge clk_sys);
        chk("secLockOutN", secLockOutN, 1'b1);
        axi_rd(ADDR_LOCK, 32'h0, RESP_OKAY);
        $display("test lock sequence done");
        lock_open();
        secDataDone <= 1'b1;
        @(posedge clk_sys);
        {secDataDone, masterTimeout} <= 2'h1;
        #1;
        chk("discardLocked", discardLocked, 1'b1);
        @(posedge clk_sys);
        masterTimeout <= 1'b0;
        #1;
        chk("sysErrN", sysErrN, 1'b0);
        chk("secLockOutN", secLockOutN, 1'b1);
        axi_rd(ADDR_STAT, 32'h1, RESP_OKAY);
        axi_wr(ADDR_STAT, 32'h1, RESP_OKAY);
        axi_rd(ADDR_STAT, 32'h0, RESP_OKAY);
        $display("test master timeout done");
        lock_open();
        secTabort <= 1'b1;
        @(posedge clk_sys);
        {secTabort, repeatHit} <= 2'h1;
        #1;
        chk("termTabort", termTabort, 1'b1);
        @(posedge clk_sys);
        repeatHit <= 1'b0;
        axi_rd(ADDR_LOCK, 32'h0, RESP_OKAY);
        chk("secLockOutN", secLockOutN, 1'b1);
        $display("test locked abort done");
        upDelayedHead <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("primReqN", primReqN, 1'b0);
        for (int i = 0; i < 12 && primStart !== 1'b1; i++) @(negedge clk_sys);
        chk("primStart", primStart, 1'b1);
        @(posedge clk_sys);
        primTermRetry <= 1'b1;
        @(posedge clk_sys);
        primTermRetry <= 1'b0;
        repeat (2)
        begin
            #1;
            chk("primReqN", primReqN, 1'b1);
            chk("primParkOe", primParkOe, 1'b1);
            @(posedge clk_sys);
        end
        chk("primAdOut", primAdOut, PARK_AD);
        chk("parkRest", {primCbeOut, primParOut}, {PARK_CBE, ^{PARK_AD, PARK_CBE}});
        upDelayedHead <= 1'b0;
        repeat (2) @(posedge clk_sys);
        // A posted write requests one cycle after its select and keeps requesting while it pends.
        {upPostedPend, upPostedSel} <= 2'h3;
        @(posedge clk_sys);
        upPostedSel <= 1'b0;
        #1;
        chk("primReqN", primReqN, 1'b0);
        @(posedge clk_sys);
        upPostedPend <= 1'b0;
        #1;
        chk("primReqN", primReqN, 1'b0);
        $display("test primary request done");
        complete_run();
    end
endmodule : test_blk_lock_ctl

`default_nettype wire
